// File: logic/pmtr_top.sv
/*
 Read side of the program store: fetch, reset vector and table reads, plus
 the pin roles of the serial programming and debug ports.
 Assumes the core holds a table request steady until done_o, and that it
 advances the program counter through pc_load/pc_inc strobes.
*/
`timescale 1ns/1ns
`include "pmtr_defines.svh"
module pmtr_top #(
	parameter int AW = `PMTR_ADDR_W,
	parameter bit EMULATION = 1'b0
) (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// Program counter control.
	input wire logic pc_inc_i,
	input wire logic pc_load_i,
	input wire logic [AW-1:0] pc_new_i,
	output logic [AW-1:0] pc_o,
	output logic [`PMTR_DATA_W-1:0] instr_o,
	// Table pointers and table request.
	input wire logic [7:0] tbl_ptr_lo_i,
	input wire logic [7:0] tbl_ptr_hi_i,
	input wire pmtr_pkg::pmtr_treq_t treq_i,
	output logic done_o,
	output logic illegal_o,
	output pmtr_pkg::pmtr_wr_t wr_o,
	// Software access to the table high byte latch.
	input wire logic latch_we_i,
	input wire logic [7:0] latch_wdata_i,
	output logic [7:0] table_high_byte_latch_o,
	// Programming port pins.
	input wire logic in_circuit_programming_i,
	input wire pmtr_pkg::pmtr_pin_in_t prog_pin_i,
	input wire logic prog_tx_i,
	input wire logic prog_tx_en_i,
	output logic prog_serial_data_o,
	output logic prog_serial_data_oe_o,
	output logic prog_rx_o,
	output logic prog_clk_o,
	input wire logic [AW-1:0] prog_waddr_i,
	input wire logic [`PMTR_DATA_W-1:0] prog_wdata_i,
	input wire logic prog_we_i,
	// Debug port pins and alternate function sharing them.
	input wire pmtr_pkg::pmtr_pin_in_t dbg_pin_i,
	input wire logic dbg_tx_i,
	input wire logic dbg_tx_en_i,
	output logic debug_serial_data_o,
	output logic debug_serial_data_oe_o,
	output logic dbg_rx_o,
	output logic dbg_clk_o,
	input wire logic alt_out_i,
	input wire logic alt_oe_i,
	output logic alt_in_o
);
	import pmtr_pkg::*;

	typedef enum logic [1:0] {PMTR_IDLE, PMTR_CYC1, PMTR_CYC2} pmtr_state_t;

	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [AW-1:0] pc_q, pc_d;
	pmtr_state_t st_q, st_d;
	logic [7:0] latch_q, latch_d;
	pmtr_wr_t wr_q, wr_d;
	logic done_q, done_d;
	logic illegal_q, illegal_d;
	logic [AW-1:0] raddr, tbl_addr;
	logic [`PMTR_DATA_W-1:0] rdata;
	logic short_op, last_op;
	logic [1:0] prog_d_s, prog_c_s, dbg_d_s, dbg_c_s;

	// Reset is released through two flops so every flop reset by rst_n leaves reset together.
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Table address: pointer pair, or the last page with the low pointer as offset.
	assign short_op = (treq_i.op == PMTR_OP_SHORT) || (treq_i.op == PMTR_OP_SHORT_LAST);
	assign last_op = (treq_i.op == PMTR_OP_SHORT_LAST) || (treq_i.op == PMTR_OP_EXT_LAST);
	always_comb begin
		if (last_op) begin
			tbl_addr = {`PMTR_LAST_PAGE, tbl_ptr_lo_i};
		end else begin
			tbl_addr = {tbl_ptr_hi_i[AW-9:0], tbl_ptr_lo_i};
		end
	end
	// The store serves the table read while one runs, otherwise the fetch.
	assign raddr = (st_q == PMTR_IDLE && !treq_i.valid) ? pc_q : tbl_addr;

	pmtr_mem #(.AW(AW), .DW(`PMTR_DATA_W)) u_mem (
		.clk_i(clk_sys_i),
		.raddr_i(raddr),
		.rdata_o(rdata),
		.we_i(prog_we_i & in_circuit_programming_i),
		.waddr_i(prog_waddr_i),
		.wdata_i(prog_wdata_i)
	);

	// Program counter next value.
	always_comb begin
		pc_d = pc_q;
		if (pc_load_i) begin
			pc_d = pc_new_i;
		end else if (pc_inc_i) begin
			pc_d = AW'(pc_q + 1'b1);
		end
	end

	// Table read sequence: cycle one reads the store, cycle two moves both bytes.
	always_comb begin
		st_d = st_q;
		latch_d = latch_q;
		wr_d = '0;
		done_d = 1'b0;
		illegal_d = 1'b0;
		if (latch_we_i) begin
			latch_d = latch_wdata_i;
		end
		unique case (st_q)
			PMTR_IDLE: begin
				if (treq_i.valid) begin
					if (short_op && treq_i.sector != `PMTR_SECTOR0) begin
						illegal_d = 1'b1;
						done_d = 1'b1;
					end else begin
						st_d = PMTR_CYC1;
					end
				end
			end
			PMTR_CYC1: begin
				st_d = PMTR_CYC2;
			end
			PMTR_CYC2: begin
				wr_d.valid = 1'b1;
				wr_d.sector = treq_i.sector;
				wr_d.reg_addr = treq_i.reg_addr;
				wr_d.data = rdata[7:0];
				latch_d = '0;
				latch_d[`PMTR_HI_USED-1:0] = rdata[15:8];
				done_d = 1'b1;
				st_d = PMTR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			pc_q <= `PMTR_RESET_VEC;
			st_q <= PMTR_IDLE;
			latch_q <= `PMTR_LATCH_RST;
			wr_q <= '0;
			done_q <= 1'b0;
			illegal_q <= 1'b0;
		end else begin
			pc_q <= pc_d;
			st_q <= st_d;
			latch_q <= latch_d;
			wr_q <= wr_d;
			done_q <= done_d;
			illegal_q <= illegal_d;
		end
	end

	assign pc_o = pc_q;
	assign instr_o = rdata;
	assign wr_o = wr_q;
	assign done_o = done_q;
	assign illegal_o = illegal_q;
	assign table_high_byte_latch_o = latch_q;

	// Pin inputs come from outside the clock domain, so two flops each.
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			prog_d_s <= 2'h0;
			prog_c_s <= 2'h0;
			dbg_d_s <= 2'h0;
			dbg_c_s <= 2'h0;
		end else begin
			prog_d_s <= {prog_d_s[0], prog_pin_i.dat_in};
			prog_c_s <= {prog_c_s[0], prog_pin_i.clk_in};
			dbg_d_s <= {dbg_d_s[0], dbg_pin_i.dat_in};
			dbg_c_s <= {dbg_c_s[0], dbg_pin_i.clk_in};
		end
	end

	// Programming line is shared both ways; the programmer owns the clock.
	assign prog_serial_data_o = prog_tx_i;
	assign prog_serial_data_oe_o = in_circuit_programming_i & prog_tx_en_i;
	assign prog_rx_o = prog_d_s[1];
	assign prog_clk_o = prog_c_s[1];

	// Debug port; in the emulation part the shared alternate function is cut off.
	assign debug_serial_data_o = EMULATION ? dbg_tx_i : alt_out_i;
	assign debug_serial_data_oe_o = EMULATION ? dbg_tx_en_i : alt_oe_i;
	assign dbg_rx_o = EMULATION ? dbg_d_s[1] : 1'b0;
	assign dbg_clk_o = EMULATION ? dbg_c_s[1] : 1'b0;
	assign alt_in_o = EMULATION ? 1'b0 : dbg_d_s[1];

	// Reset vector holds right after release.
	pc_reset_a: assert property (@(posedge clk_sys_i)
		$rose(rst_n) |-> pc_q == `PMTR_RESET_VEC)
		else $error("pc not at reset vector");
	// Two cycles busy after accept, so done and the byte are seen at the third edge.
	two_cycle_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		(st_q == PMTR_IDLE && st_d == PMTR_CYC1) |-> ##3 (done_q && wr_q.valid))
		else $error("table read not done in two cycles");
	// Short forms outside sector 0 never write.
	short_sector_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		(st_q == PMTR_IDLE && treq_i.valid && short_op && treq_i.sector != `PMTR_SECTOR0)
		|=> (illegal_q && !wr_q.valid))
		else $error("short table read outside sector 0");
	// Low byte lands in the write, high byte in the latch.
	byte_split_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		wr_q.valid |-> (wr_q.data == $past(rdata[7:0]) && latch_q == $past(rdata[15:8])))
		else $error("table bytes misrouted");
	// Software write reaches the latch unless a table read loads it in the same cycle.
	latch_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		(latch_we_i && st_q != PMTR_CYC2) |=> latch_q == $past(latch_wdata_i))
		else $error("latch write lost");
	// The store itself sees the last page when a last-page form starts.
	last_page_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		(st_q == PMTR_IDLE && treq_i.valid && last_op) |-> raddr[AW-1:8] == `PMTR_LAST_PAGE)
		else $error("last page address wrong");
	// The store itself sees the pointer pair when a plain form starts.
	ptr_concat_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		(st_q == PMTR_IDLE && treq_i.valid && !last_op)
		|-> raddr == {tbl_ptr_hi_i[AW-9:0], tbl_ptr_lo_i})
		else $error("pointer concat wrong");
	// Alternate function silent in emulation.
	alt_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		EMULATION |-> (alt_in_o == 1'b0 && debug_serial_data_oe_o == dbg_tx_en_i))
		else $error("alternate function active on debug pin");
	// Programming driver only during programming.
	prog_drive_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		!in_circuit_programming_i |-> !prog_serial_data_oe_o)
		else $error("programming line driven outside programming");
endmodule // pmtr_top

// File: logic/pmtr_defines.svh
/*
 Constants for the program memory table-read block: sizes, vectors, page, sector and latch values.
 Assumes it is included by bare name wherever these values are needed.
*/
`ifndef PMTR_DEFINES_SVH
`define PMTR_DEFINES_SVH
`define PMTR_ADDR_W 13
`define PMTR_DATA_W 16
`define PMTR_DEPTH 8192
`define PMTR_RESET_VEC 13'h0000
`define PMTR_LAST_PAGE 5'h1F
`define PMTR_SECTOR0 2'h0
`define PMTR_LATCH_RST 8'h00
`define PMTR_HI_USED 8
`endif

// File: logic/pmtr_pkg.sv
/*
 Types shared by the table-read block, its core model and the bench.
 Assumes the defines header is on the include path.
*/
`include "pmtr_defines.svh"
package pmtr_pkg;
	// Table-read request from the core.
	typedef enum logic [1:0] {
		PMTR_OP_SHORT,
		PMTR_OP_SHORT_LAST,
		PMTR_OP_EXT,
		PMTR_OP_EXT_LAST
	} pmtr_op_t;
	typedef struct packed {
		logic valid;
		pmtr_op_t op;
		logic [1:0] sector;
		logic [7:0] reg_addr;
	} pmtr_treq_t;
	// Byte delivered to the data memory.
	typedef struct packed {
		logic valid;
		logic [1:0] sector;
		logic [7:0] reg_addr;
		logic [7:0] data;
	} pmtr_wr_t;
	// Raw levels of one serial port's pins: data line and clock line.
	typedef struct packed {
		logic dat_in;
		logic clk_in;
	} pmtr_pin_in_t;
endpackage

// File: logic/pmtr_mem.sv
/*
 Program store of the table-read block, one read port with registered data.
 Assumes contents are loaded by the programming path.
*/
`timescale 1ns/1ns
`include "pmtr_defines.svh"
module pmtr_mem #(
	parameter int AW = `PMTR_ADDR_W,
	parameter int DW = `PMTR_DATA_W
) (
	// Clock.
	input wire logic clk_i,
	// Read port.
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o,
	// Write port for programming.
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	// Store is 8K by 16; read data leave through a register.
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule // pmtr_mem

// File: test/pmtr_core_model.sv
/*
 Core model for the table-read block: issues one table request per start pulse.
 Assumes the block answers with done_i and wr_i as pulses one cycle long.
*/
`timescale 1ns/1ns
module pmtr_core_model import pmtr_pkg::*; (
	// Clock and command from the bench.
	input wire logic clk_i,
	input wire logic start_i,
	input wire pmtr_pkg::pmtr_treq_t cmd_i,
	// Answer from the block.
	input wire logic done_i,
	input wire logic illegal_i,
	input wire pmtr_pkg::pmtr_wr_t wr_i,
	// Request to the block and what came back.
	output pmtr_pkg::pmtr_treq_t treq_o,
	output logic busy_o,
	output int lat_o,
	output logic ill_o,
	output pmtr_pkg::pmtr_wr_t wr_o
);
	pmtr_treq_t cmd_q;
	int cnt_q;
	// Valid falls in the done cycle itself, else the block would start a second read.
	always_comb begin
		treq_o = cmd_q;
		treq_o.valid = busy_o && !done_i;
	end
	// Nothing is requested before the first start.
	initial busy_o = 1'b0;
	// Counts edges from the request and keeps the byte and refusal that came back.
	always @(posedge clk_i) begin
		if (start_i) begin
			cmd_q <= cmd_i;
			busy_o <= 1'b1;
			cnt_q <= 0;
			ill_o <= 1'b0;
			wr_o <= '0;
		end else if (busy_o) begin
			cnt_q <= cnt_q + 1;
			if (wr_i.valid)
				wr_o <= wr_i;
			if (done_i) begin
				busy_o <= 1'b0;
				ill_o <= illegal_i;
				lat_o <= cnt_q;
			end
		end
	end
endmodule // pmtr_core_model

// File: test/testbench.sv
/*
 Self-checking bench for the table-read block: fetch, table reads, refusals, pins.
 Assumes the design files and the core model are compiled before it.
*/
`timescale 1ns/1ns
module testbench import pmtr_pkg::*;;
	logic clk_sys_i = 0, nrst_i = 0, pc_inc_i = 0, pc_load_i = 0, lwe = 0, in_circuit_programming = 0;
	logic tx_en = 0, we = 0, start = 0, done, ill, busy, got_ill, poe, prx, drx;
	logic pso, pclk, dso, doe, dclk, ain;
	logic [12:0] pc_new = '0, waddr = '0, pc;
	logic [7:0] ptr_lo = '0, ptr_hi = '0, lwd = '0, latch;
	logic [15:0] wdata = '0, instr;
	pmtr_pin_in_t ppin = '0, dpin = '0;
	pmtr_treq_t cmd = '0, treq;
	pmtr_wr_t wr, seen;
	int lat, n_mismatch = 0, checks_done = 0, cyc = 0;
	// Clock of 50 ns.
	always #25 clk_sys_i = ~clk_sys_i;
	// The emulation build is used so that the debug port and its cut-off are exercised.
	pmtr_top #(.EMULATION(1'b1)) uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .pc_inc_i(pc_inc_i),
		.pc_load_i(pc_load_i), .pc_new_i(pc_new), .pc_o(pc), .instr_o(instr),
		.tbl_ptr_lo_i(ptr_lo), .tbl_ptr_hi_i(ptr_hi), .treq_i(treq), .done_o(done),
		.illegal_o(ill), .wr_o(wr), .latch_we_i(lwe), .latch_wdata_i(lwd),
		.table_high_byte_latch_o(latch), .in_circuit_programming_i(in_circuit_programming),
		.prog_pin_i(ppin), .prog_tx_i(1'b1), .prog_tx_en_i(tx_en),
		.prog_serial_data_o(pso), .prog_serial_data_oe_o(poe), .prog_rx_o(prx),
		.prog_clk_o(pclk), .prog_waddr_i(waddr), .prog_wdata_i(wdata), .prog_we_i(we),
		.dbg_pin_i(dpin), .dbg_tx_i(1'b1), .dbg_tx_en_i(1'b0), .debug_serial_data_o(dso),
		.debug_serial_data_oe_o(doe), .dbg_rx_o(drx), .dbg_clk_o(dclk), .alt_out_i(1'b0),
		.alt_oe_i(1'b1), .alt_in_o(ain));
	pmtr_core_model core (.clk_i(clk_sys_i), .start_i(start), .cmd_i(cmd), .done_i(done),
		.illegal_i(ill), .wr_i(wr), .treq_o(treq), .busy_o(busy), .lat_o(lat),
		.ill_o(got_ill), .wr_o(seen));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// A hang counts as a mismatch; the whole run needs well under 1000 cycles.
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc > 3000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	task automatic wmem(input logic [12:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		waddr <= a;
		wdata <= d;
		we <= 1'b1;
		in_circuit_programming <= 1'b1;
	endtask
	task automatic tread(input pmtr_op_t op, input logic [1:0] sec,
		input logic [7:0] ra, input logic [7:0] hi, input logic [7:0] lo);
		int i;
		@(posedge clk_sys_i);
		ptr_hi <= hi;
		ptr_lo <= lo;
		cmd <= '{1'b1, op, sec, ra};
		start <= 1'b1;
		@(posedge clk_sys_i);
		start <= 1'b0;
		// Busy is only looked at from the next edge on, after the model has raised it.
		i = 0;
		do begin
			@(posedge clk_sys_i);
			i++;
		end while (busy !== 1'b0 && i < 20);
		@(negedge clk_sys_i);
	endtask
	task automatic s_fetch();
		repeat (3) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk(pc, 13'h0000);
		chk(instr, 16'h1234);
		@(posedge clk_sys_i);
		pc_load_i <= 1'b1;
		pc_new <= 13'h0A47;
		@(posedge clk_sys_i);
		pc_load_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		pc_inc_i <= 1'b1;
		@(negedge clk_sys_i);
		chk(instr, 16'hE7C8);
		@(posedge clk_sys_i);
		pc_inc_i <= 1'b0;
		@(negedge clk_sys_i);
		chk(pc, 13'h0A48);
	endtask
	// Every form in turn, back to back, covering both page choices and sectors.
	task automatic s_table();
		logic [7:0] his[4] = '{8'h1F, 8'h0A, 8'h0A, 8'h00};
		logic [7:0] los[4] = '{8'h06, 8'h05, 8'h47, 8'h06};
		logic [1:0] secs[4] = '{2'h0, 2'h0, 2'h2, 2'h3};
		logic [15:0] w[4] = '{16'h5C1A, 16'h3D0F, 16'hE7C8, 16'h5C1A};
		for (int i = 0; i < 4; i++) begin
			tread(pmtr_op_t'(i), secs[i], 8'h20 + i, his[i], los[i]);
			chk(lat, 3);
			chk(seen, {1'b1, secs[i], 8'(8'h20 + i), w[i][7:0]});
			chk(latch, w[i][15:8]);
		end
	endtask
	task automatic s_refuse();
		tread(PMTR_OP_SHORT, 2'h1, 8'h55, 8'h0A, 8'h47);
		chk(got_ill, 1'b1);
		chk(seen.valid, 1'b0);
		chk(lat, 1);
		chk(latch, 8'h5C);
	endtask
	task automatic s_latch();
		@(posedge clk_sys_i);
		lwe <= 1'b1;
		lwd <= 8'hA5;
		@(posedge clk_sys_i);
		lwe <= 1'b0;
		@(negedge clk_sys_i);
		chk(latch, 8'hA5);
		tread(PMTR_OP_SHORT_LAST, 2'h0, 8'h66, 8'h00, 8'h05);
		chk(latch, 8'h3D);
	endtask
	// Pin levels pass through two flops; the data pin is driven only in programming.
	task automatic s_pins();
		@(posedge clk_sys_i);
		ppin <= '{1'b1, 1'b1};
		dpin <= '{1'b1, 1'b1};
		tx_en <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk(prx, 1'b1);
		chk(pclk, 1'b1);
		chk(drx, 1'b1);
		chk(dclk, 1'b1);
		chk(dso, 1'b1);
		chk(ain, 1'b0);
		chk(doe, 1'b0);
		chk(poe, 1'b0);
		@(posedge clk_sys_i);
		// With programming on, the block drives the programming data line from prog_tx_i.
		in_circuit_programming <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk(poe, 1'b1);
		chk(pso, 1'b1);
	endtask
	// Reset for two cycles, load the store through the programming port, then run.
	initial begin
		repeat (2) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		wmem(13'h0000, 16'h1234);
		wmem(13'h0A47, 16'hE7C8);
		wmem(13'h1F05, 16'h3D0F);
		wmem(13'h1F06, 16'h5C1A);
		@(posedge clk_sys_i);
		we <= 1'b0;
		in_circuit_programming <= 1'b0;
		s_fetch();
		s_table();
		s_refuse();
		s_latch();
		s_pins();
		tally_and_finish();
	end
endmodule // testbench
